// ---- logic/sdo_cfg.svh ----
// Purpose: Named constants of the segmented upload server.
// Assumes: Included by the package and the server only.
// Notes:   Byte positions count from byte 0 of the eight-byte payload.
`ifndef SDO_CFG_SVH
`define SDO_CFG_SVH

// ==========================================================================
// Frame identifiers and length
`define SDO_DLC_FULL      4'h8
`define SDO_ID_REQ_BASE   11'h600
`define SDO_ID_RSP_BASE   11'h580
`define SDO_NODE_W        7

// ==========================================================================
// Byte positions within the payload
`define SDO_B_CMD         0
`define SDO_B_IDX_LO      1
`define SDO_B_IDX_HI      2
`define SDO_B_SUB         3
`define SDO_B_DATA        4
`define SDO_B_SEG         1

// ==========================================================================
// Command byte fields
`define SDO_CCS_HI        7
`define SDO_CCS_LO        5
`define SDO_TOG_BIT       4
`define SDO_N_HI          3
`define SDO_N_LO          1
`define SDO_C_BIT         0
`define SDO_CCS_UPL_INIT  3'h2
`define SDO_CCS_SEG_REQ   3'h3
`define SDO_CCS_ABORT     3'h4

// ==========================================================================
// Response command codes, segment byte limit and whole-object subindex
`define SDO_CMD_ABORT     8'h80
`define SDO_RSP_NORMAL    8'h41
`define SDO_RSP_EXP1      8'h4F
`define SDO_RSP_EXP2      8'h4B
`define SDO_RSP_SEG       8'h00
`define SDO_SEG_MAX       3'h7
`define SDO_SUB_WHOLE     8'h00

// ==========================================================================
// Abort codes
`define SDO_ABT_TOGGLE    32'h05030000
`define SDO_ABT_CMD       32'h05040001
`define SDO_ABT_NO_OBJ    32'h06020000
`define SDO_ABT_NO_SUB    32'h06090011

`endif

// ---- logic/sdo_pkg.sv ----
// Purpose: Types shared by the segmented upload server files.
// Assumes: Constants come from sdo_cfg.svh.
// Notes:   Payload byte i is data[i].
`include "sdo_cfg.svh"

package sdo_pkg;

   // =======================================================================
   // Frame carrier
   typedef struct packed {
      logic [10:0]     id;
      logic [3:0]      dlc;
      logic [7:0][7:0] data;
   } sdo_frame_s;

   // =======================================================================
   // Server states
   typedef enum logic [4:0] {
      SDO_ST_IDLE   = 5'b00001,
      SDO_ST_DECODE = 5'b00010,
      SDO_ST_FETCH  = 5'b00100,
      SDO_ST_CATCH  = 5'b01000,
      SDO_ST_SEND   = 5'b10000
   } sdo_state_e;

endpackage : sdo_pkg

// ---- logic/sdo_mem.sv ----
// Purpose: Byte store holding the string object served by the server.
// Assumes: One write port from user logic, one read port from the server.
// Notes:   Read data appear one clock after the address.
`timescale 1ns/1ps

module sdo_mem #(
   parameter int AW = 8
) (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst,
   // Write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [7:0]    wr_data,
   // Read port
   input  wire logic [AW-1:0] rd_addr,
   output logic      [7:0]    rd_data
);

   logic [7:0] mem_r [0:(1<<AW)-1];
   logic [7:0] rd_data_r;
   logic [7:0] rd_data_nxt;

   // The array has no reset; only the read register is cleared.
   always_comb begin
      rd_data_nxt = mem_r[rd_addr];
   end

   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
      if (rst) begin
         rd_data_r <= 8'h00;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data = rd_data_r;

endmodule // sdo_mem

// ---- logic/sdo_server.sv ----
// Purpose: Upload server for service-data-object frames of one node.
// Assumes: Frames arrive whole, one per rx_valid pulse, on this clock.
// Notes:   Serves one two-byte word object and one string object.
//
// Contract
// RQ1: Two-byte upload replies 4B, index, sub, value.
// RQ2: Every frame has eight bytes, zero padded.
// RQ3: One response per segment request.
// RQ4: String characters readable from subindex one onward.
// RQ5: Client opens with initiate code, index, sub.
// RQ6: Initiate reply carries length in data bytes.
// RQ7: Initiate reply command marks normal, size indicated.
// RQ8: Client segment request codes differ by toggle.
// RQ9: Client inverts toggle, starts every transfer clear.
// RQ10: Response copies the request toggle unchanged.
// RQ11: Three-bit field counts unused trailing bytes.
// RQ12: Last-segment flag set only in final response.
// RQ13: Segments carry up to seven bytes.
// RQ14: Abort frame carries code, index, sub, error.
// RQ15: Abort ends transfer at once, not confirmed.
// RQ16: Received abort error code is ignored.
// RQ17: Requests on 600h plus node, answers 580h.
// RQ18: Unalternated toggle aborts with toggle error.
// RQ19: Unknown command aborts with command error.
// RQ20: Count bytes sent; reset on initiate or abort.
// RQ21: One open transfer; new initiate discards old.
`timescale 1ns/1ps
`include "sdo_cfg.svh"

module sdo_server
   import sdo_pkg::*;
#(
   parameter int MEM_AW = 8
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   // Frame link
   input  wire logic              rx_valid,
   input  wire sdo_frame_s        rx_frame,
   output sdo_frame_s             tx_frame,
   output logic                   tx_valid,
   // Configuration
   input  wire logic [6:0]        node_id,
   input  wire logic [15:0]       word_index,
   input  wire logic [15:0]       word_value,
   input  wire logic [15:0]       str_index,
   input  wire logic [MEM_AW:0]   str_len,
   // String store load
   input  wire logic              obj_wr_en,
   input  wire logic [MEM_AW-1:0] obj_wr_addr,
   input  wire logic [7:0]        obj_wr_data,
   // Status
   output logic                   busy,
   output logic                   xfer_open,
   output logic                   abort_rcvd
);

   // =======================================================================
   // Elaboration check
   if (MEM_AW < 3 || MEM_AW > 16) begin : g_bad_aw
      $error("sdo_server: MEM_AW must lie in 3..16");
   end

   // =======================================================================
   // State
   sdo_state_e            state_r,   state_nxt;
   sdo_frame_s            req_r,     req_nxt;
   sdo_frame_s            frm_r,     frm_nxt;
   sdo_frame_s            tx_frm_r,  tx_frm_nxt;
   logic                  tx_vld_r,  tx_vld_nxt;
   logic [MEM_AW:0]       sent_r,    sent_nxt;
   logic [MEM_AW:0]       len_r,     len_nxt;
   logic [MEM_AW-1:0]     base_r,    base_nxt;
   logic [2:0]            k_r,       k_nxt;
   logic [2:0]            cnt_r,     cnt_nxt;
   logic                  tog_r,     tog_nxt;
   logic                  open_r,    open_nxt;
   logic                  busy_r,    busy_nxt;
   logic                  abt_r,     abt_nxt;

   logic [7:0]            rd_data;
   logic [MEM_AW-1:0]     rd_addr;
   logic [10:0]           req_id;
   logic [10:0]           rsp_id;
   logic [15:0]           idx;
   logic [7:0]            sub;
   logic [2:0]            ccs;
   logic [MEM_AW:0]       remain;
   logic [MEM_AW:0]       sub_ext;

   // =======================================================================
   // String store
   sdo_mem #(
      .AW      (MEM_AW)
   ) u_mem (
      .clock   (clock),
      .rst     (rst),
      .wr_en   (obj_wr_en),
      .wr_addr (obj_wr_addr),
      .wr_data (obj_wr_data),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   // =======================================================================
   // Frame helpers
   function automatic sdo_frame_s mk_frame(input logic [10:0] id,
                                           input logic [7:0]  cmd,
                                           input logic [15:0] ix,
                                           input logic [7:0]  sb,
                                           input logic [31:0] val);
      sdo_frame_s f;
      f                    = '0;
      f.id                 = id;
      f.dlc                = `SDO_DLC_FULL;                  // RQ2
      f.data[`SDO_B_CMD]   = cmd;
      f.data[`SDO_B_IDX_LO] = ix[7:0];
      f.data[`SDO_B_IDX_HI] = ix[15:8];
      f.data[`SDO_B_SUB]   = sb;
      f.data[`SDO_B_DATA+0] = val[7:0];
      f.data[`SDO_B_DATA+1] = val[15:8];
      f.data[`SDO_B_DATA+2] = val[23:16];
      f.data[`SDO_B_DATA+3] = val[31:24];
      return f;
   endfunction

   // =======================================================================
   // Decode of the held request
   assign req_id  = `SDO_ID_REQ_BASE + {4'h0, node_id};     // RQ17
   assign rsp_id  = `SDO_ID_RSP_BASE + {4'h0, node_id};     // RQ17
   assign idx     = {req_r.data[`SDO_B_IDX_HI], req_r.data[`SDO_B_IDX_LO]};
   assign sub     = req_r.data[`SDO_B_SUB];
   assign ccs     = req_r.data[`SDO_B_CMD][`SDO_CCS_HI:`SDO_CCS_LO];
   assign remain  = len_r - sent_r;
   assign sub_ext = (MEM_AW+1)'(sub);
   assign rd_addr = base_r + MEM_AW'(k_r);

   // =======================================================================
   // Next-state logic
   always_comb begin
      state_nxt  = state_r;
      req_nxt    = req_r;
      frm_nxt    = frm_r;
      tx_frm_nxt = tx_frm_r;
      tx_vld_nxt = 1'b0;
      sent_nxt   = sent_r;
      len_nxt    = len_r;
      base_nxt   = base_r;
      k_nxt      = k_r;
      cnt_nxt    = cnt_r;
      tog_nxt    = tog_r;
      open_nxt   = open_r;
      abt_nxt    = 1'b0;

      unique case (state_r)
         SDO_ST_IDLE: begin
            // Short frames and other identifiers are not ours to answer.
            if (rx_valid && rx_frame.id == req_id &&
                rx_frame.dlc == `SDO_DLC_FULL) begin        // RQ2 RQ17
               req_nxt   = rx_frame;
               state_nxt = SDO_ST_DECODE;
            end
         end

         SDO_ST_DECODE: begin
            state_nxt = SDO_ST_SEND;
            k_nxt     = 3'h0;
            cnt_nxt   = 3'h0;
            if (ccs == `SDO_CCS_ABORT) begin
               // The error code bytes are never looked at.
               open_nxt  = 1'b0;                             // RQ15 RQ16
               sent_nxt  = '0;                               // RQ20
               tog_nxt   = 1'b0;
               abt_nxt   = 1'b1;
               state_nxt = SDO_ST_IDLE;                      // RQ15
            end else if (ccs == `SDO_CCS_UPL_INIT) begin
               // Any open transfer is dropped by a new initiate.
               open_nxt = 1'b0;                              // RQ21
               sent_nxt = '0;                                // RQ20
               tog_nxt  = 1'b0;
               if (idx == str_index && sub == `SDO_SUB_WHOLE) begin
                  len_nxt  = str_len;
                  open_nxt = 1'b1;                           // RQ3
                  frm_nxt  = mk_frame(rsp_id, `SDO_RSP_NORMAL, idx, sub,
                                      32'(str_len));         // RQ6 RQ7
               end else if (idx == str_index &&
                            sub_ext <= str_len) begin
                  base_nxt  = MEM_AW'(sub_ext - 1'b1);       // RQ4
                  cnt_nxt   = 3'h1;
                  frm_nxt   = mk_frame(rsp_id, `SDO_RSP_EXP1, idx, sub,
                                       32'h00000000);        // RQ4
                  state_nxt = SDO_ST_FETCH;
               end else if (idx == word_index &&
                            sub == `SDO_SUB_WHOLE) begin
                  frm_nxt = mk_frame(rsp_id, `SDO_RSP_EXP2, idx, sub,
                                     {16'h0000, word_value}); // RQ1
               end else if (idx == str_index || idx == word_index) begin
                  frm_nxt = mk_frame(rsp_id, `SDO_CMD_ABORT, idx, sub,
                                     `SDO_ABT_NO_SUB);       // RQ14
               end else begin
                  frm_nxt = mk_frame(rsp_id, `SDO_CMD_ABORT, idx, sub,
                                     `SDO_ABT_NO_OBJ);       // RQ14
               end
            end else if (ccs == `SDO_CCS_SEG_REQ && open_r) begin
               if (req_r.data[`SDO_B_CMD][`SDO_TOG_BIT] != tog_r) begin
                  open_nxt = 1'b0;
                  sent_nxt = '0;
                  tog_nxt  = 1'b0;
                  frm_nxt  = mk_frame(rsp_id, `SDO_CMD_ABORT, idx, sub,
                                      `SDO_ABT_TOGGLE);      // RQ18
               end else begin
                  frm_nxt = mk_frame(rsp_id, `SDO_RSP_SEG, 16'h0000,
                                     8'h00, 32'h00000000);   // RQ2 RQ3
                  frm_nxt.data[`SDO_B_CMD][`SDO_TOG_BIT] = tog_r; // RQ10
                  base_nxt = sent_r[MEM_AW-1:0];
                  if (remain <= (MEM_AW+1)'(`SDO_SEG_MAX)) begin
                     cnt_nxt  = remain[2:0];
                     frm_nxt.data[`SDO_B_CMD][`SDO_N_HI:`SDO_N_LO] =
                        `SDO_SEG_MAX - remain[2:0];          // RQ11
                     frm_nxt.data[`SDO_B_CMD][`SDO_C_BIT] = 1'b1; // RQ12
                     open_nxt = 1'b0;
                     sent_nxt = len_r;                       // RQ20
                     tog_nxt  = 1'b0;
                  end else begin
                     cnt_nxt  = `SDO_SEG_MAX;                // RQ13
                     sent_nxt = sent_r + (MEM_AW+1)'(`SDO_SEG_MAX); // RQ20
                     tog_nxt  = ~tog_r;
                  end
                  if (cnt_nxt != 3'h0) begin
                     state_nxt = SDO_ST_FETCH;
                  end
               end
            end else begin
               // A segment request with nothing open counts as unknown.
               open_nxt = 1'b0;
               sent_nxt = '0;
               tog_nxt  = 1'b0;
               frm_nxt  = mk_frame(rsp_id, `SDO_CMD_ABORT, idx, sub,
                                   `SDO_ABT_CMD);            // RQ19
            end
         end

         SDO_ST_FETCH: begin
            state_nxt = SDO_ST_CATCH;
         end

         SDO_ST_CATCH: begin
            if (cnt_r == 3'h1 && frm_r.data[`SDO_B_CMD] == `SDO_RSP_EXP1)
            begin
               frm_nxt.data[`SDO_B_DATA] = rd_data;          // RQ4
            end else begin
               frm_nxt.data[`SDO_B_SEG + k_r] = rd_data;     // RQ13
            end
            k_nxt = k_r + 3'h1;
            if (k_nxt == cnt_r) begin
               state_nxt = SDO_ST_SEND;
            end else begin
               state_nxt = SDO_ST_FETCH;
            end
         end

         SDO_ST_SEND: begin
            tx_frm_nxt = frm_r;
            tx_vld_nxt = 1'b1;                               // RQ3
            state_nxt  = SDO_ST_IDLE;
         end

         default: begin
            state_nxt = SDO_ST_IDLE;
         end
      endcase

      busy_nxt = (state_nxt != SDO_ST_IDLE);
   end

   // =======================================================================
   // Registers
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r  <= SDO_ST_IDLE;
         req_r    <= '0;
         frm_r    <= '0;
         tx_frm_r <= '0;
         tx_vld_r <= 1'b0;
         sent_r   <= '0;
         len_r    <= '0;
         base_r   <= '0;
         k_r      <= 3'h0;
         cnt_r    <= 3'h0;
         tog_r    <= 1'b0;
         open_r   <= 1'b0;
         busy_r   <= 1'b0;
         abt_r    <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         req_r    <= req_nxt;
         frm_r    <= frm_nxt;
         tx_frm_r <= tx_frm_nxt;
         tx_vld_r <= tx_vld_nxt;
         sent_r   <= sent_nxt;
         len_r    <= len_nxt;
         base_r   <= base_nxt;
         k_r      <= k_nxt;
         cnt_r    <= cnt_nxt;
         tog_r    <= tog_nxt;
         open_r   <= open_nxt;
         busy_r   <= busy_nxt;
         abt_r    <= abt_nxt;
      end
   end

   // =======================================================================
   // Outputs
   assign tx_frame   = tx_frm_r;
   assign tx_valid   = tx_vld_r;
   assign busy       = busy_r;
   assign xfer_open  = open_r;
   assign abort_rcvd = abt_r;

endmodule // sdo_server

// ---- testbench/sdo_server_assertions.sv ----
// Purpose: Port-level timing and format checks of the upload server.
// Assumes: Bound into every sdo_server instance; one clock domain.
// Notes:   Toggle of the last taken request is kept in helper logic.
`timescale 1ns/1ps

// ==========================================================================
// Checker
module sdo_server_assertions
   import sdo_pkg::*;
#(
   parameter int MEM_AW = 8
) (
   // Clock and reset
   input wire logic              clock,
   input wire logic              rst,
   // Frame link
   input wire logic              rx_valid,
   input wire sdo_frame_s        rx_frame,
   input wire sdo_frame_s        tx_frame,
   input wire logic              tx_valid,
   // Configuration
   input wire logic [6:0]        node_id,
   input wire logic [15:0]       word_index,
   input wire logic [15:0]       word_value,
   input wire logic [15:0]       str_index,
   input wire logic [MEM_AW:0]   str_len,
   // String store load
   input wire logic              obj_wr_en,
   input wire logic [MEM_AW-1:0] obj_wr_addr,
   input wire logic [7:0]        obj_wr_data,
   // Status
   input wire logic              busy,
   input wire logic              xfer_open,
   input wire logic              abort_rcvd
);
   logic       take;
   logic       tog_r;
   logic       tog_nxt;
   logic [2:0] n_cnt;

   assign take = rx_valid && !busy && rx_frame.dlc == 4'h8 &&
                 rx_frame.id == 11'h600 + 11'(node_id);
   assign n_cnt = tx_frame.data[0][3:1];

   always_comb begin
      tog_nxt = take ? rx_frame.data[0][4] : tog_r;
   end

   always_ff @(posedge clock) begin
      tog_r <= rst ? 1'b0 : tog_nxt;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence taken_abort;
      take && rx_frame.data[0][7:5] == 3'h4;
   endsequence
   sequence taken_answer;
      take && rx_frame.data[0][7:5] != 3'h4;
   endsequence
   sequence seg_reply;
      tx_valid && tx_frame.data[0][7:5] == 3'h0;
   endsequence

   chk_reply_frame: assert property (tx_valid |->
      tx_frame.id == 11'h580 + 11'(node_id) && tx_frame.dlc == 4'h8)
      else $error("reply id or length wrong");
   chk_tx_pulse: assert property (tx_valid |=> !tx_valid)
      else $error("tx_valid longer than one cycle");
   chk_one_answer: assert property (taken_answer |=>
      busy && !tx_valid ##1 !tx_valid ##[1:15] tx_valid)
      else $error("request not answered in time");
   chk_abort_quiet: assert property (taken_abort |=> !tx_valid[*4])
      else $error("received abort was answered");
   chk_abort_closes: assert property (taken_abort |->
      ##2 abort_rcvd && !xfer_open && !busy)
      else $error("received abort did not close transfer");
   chk_toggle_echo: assert property (seg_reply |->
      tx_frame.data[0][4] == tog_r)
      else $error("segment toggle not copied");
   chk_unused_zero: assert property (seg_reply |->
      (64'(tx_frame.data) >> (7'd64 - 7'(8 * n_cnt))) == 64'h0)
      else $error("unused segment bytes not zero");
   chk_last_closes: assert property (seg_reply and tx_frame.data[0][0]
      |=> !xfer_open)
      else $error("transfer open after last segment");
   chk_more_open: assert property (seg_reply and !tx_frame.data[0][0]
      |-> xfer_open)
      else $error("non-final segment without open transfer");
   chk_init_opens: assert property (tx_valid &&
      tx_frame.data[0] == 8'h41 |-> xfer_open)
      else $error("normal initiate reply without open transfer");
endmodule // sdo_server_assertions

bind sdo_server sdo_server_assertions #(.MEM_AW(MEM_AW)) chk_i (
   .clock(clock), .rst(rst), .rx_valid(rx_valid), .rx_frame(rx_frame),
   .tx_frame(tx_frame), .tx_valid(tx_valid), .node_id(node_id),
   .word_index(word_index), .word_value(word_value),
   .str_index(str_index), .str_len(str_len), .obj_wr_en(obj_wr_en),
   .obj_wr_addr(obj_wr_addr), .obj_wr_data(obj_wr_data), .busy(busy),
   .xfer_open(xfer_open), .abort_rcvd(abort_rcvd));

// ---- testbench/sdo_client_model.sv ----
// Purpose: Client side model that requests uploads from the server.
// Assumes: Requests are driven at the falling edge, one cycle long.
// Notes:   Last answer is kept in ans and ans_seen for the bench.
`timescale 1ns/1ps

// ==========================================================================
// Client model
module sdo_client_model
   import sdo_pkg::*;
(
   // Clock
   input  wire logic       clock,
   // Requests
   output logic            rx_valid,
   output sdo_frame_s      rx_frame,
   // Answers
   input  wire logic       tx_valid,
   input  wire sdo_frame_s tx_frame,
   input  wire logic [6:0] node_id
);
   logic       tog_r;
   logic       ans_seen;
   sdo_frame_s ans;

   initial begin
      rx_valid = 1'b0;
      rx_frame = '0;
      tog_r = 1'b0;
   end

   function automatic sdo_frame_s frm(logic [10:0] id, logic [7:0] c,
                                      logic [15:0] ix, logic [7:0] sb,
                                      logic [31:0] d);
      sdo_frame_s f;
      f = '0;
      f.id = id;
      f.dlc = 4'h8;
      f.data[0] = c;
      f.data[2:1] = ix;
      f.data[3] = sb;
      f.data[7:4] = d;
      return f;
   endfunction

   // A frame that no answer follows is waited out for the full window.
   task automatic xchg(input sdo_frame_s f);
      ans_seen = 1'b0;
      ans = '0;
      @(negedge clock);
      rx_frame = f;
      rx_valid = 1'b1;
      @(negedge clock);
      rx_valid = 1'b0;
      // Released lines show no stale copy of the request.
      rx_frame = ~f;
      for (int i = 0; i < 24 && !ans_seen; i++) begin
         @(negedge clock);
         if (tx_valid === 1'b1) begin
            ans_seen = 1'b1;
            ans = tx_frame;
         end
      end
   endtask

   task automatic init(input logic [15:0] ix, input logic [7:0] sb);
      tog_r = 1'b0;
      xchg(frm(11'h600 + 11'(node_id), 8'h40, ix, sb, 32'h0));
   endtask

   task automatic seg(input logic [15:0] ix, input logic [7:0] sb);
      xchg(frm(11'h600 + 11'(node_id), {3'h3, tog_r, 4'h0}, ix, sb,
               32'h0));
      tog_r = ~tog_r;
   endtask

   task automatic abort(input logic [15:0] ix, input logic [31:0] code);
      tog_r = 1'b0;
      xchg(frm(11'h600 + 11'(node_id), 8'h80, ix, 8'h00, code));
   endtask
endmodule // sdo_client_model

// ---- testbench/sdo_segmented_upload_server_bench.sv ----
// Purpose: Self-checking bench of the segmented upload server.
// Assumes: Client model drives requests; bench drives configuration.
// Notes:   String byte i holds 30h plus i.
`timescale 1ns/1ps

`define CHK(what, exp, got) \
   begin \
      checked++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("unexpected %s: expected %h seen %h", what, exp, got); \
      end \
   end

// ==========================================================================
// Bench
module sdo_segmented_upload_server_bench;
   import sdo_pkg::*;
   localparam int SLEN  = 17;
   localparam int LIMIT = 20000;
   logic        clock, rst, rx_valid, tx_valid, busy, xfer_open, abort_rcvd;
   logic        obj_wr_en;
   logic [7:0]  obj_wr_addr, obj_wr_data;
   logic [6:0]  node_id;
   logic [15:0] word_index, word_value, str_index;
   logic [8:0]  str_len;
   logic [10:0] rsp_id;
   sdo_frame_s  rx_frame, tx_frame;
   int          failures, checked, cycles, sent;

   assign rsp_id = 11'h580 + 11'(node_id);

   sdo_server #(.MEM_AW(8)) sdo_server_i (
      .clock(clock), .rst(rst), .rx_valid(rx_valid), .rx_frame(rx_frame),
      .tx_frame(tx_frame), .tx_valid(tx_valid), .node_id(node_id),
      .word_index(word_index), .word_value(word_value),
      .str_index(str_index), .str_len(str_len), .obj_wr_en(obj_wr_en),
      .obj_wr_addr(obj_wr_addr), .obj_wr_data(obj_wr_data), .busy(busy),
      .xfer_open(xfer_open), .abort_rcvd(abort_rcvd));

   sdo_client_model cli (
      .clock(clock), .rx_valid(rx_valid), .rx_frame(rx_frame),
      .tx_valid(tx_valid), .tx_frame(tx_frame), .node_id(node_id));

   initial clock = 1'b0;
   always #4 clock = ~clock;

   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         close_out();
      end
   end

   function automatic logic [7:0] chr(int i);
      return 8'(8'h30 + i);
   endfunction

   task automatic close_out;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic expect_ans(input sdo_frame_s e);
      `CHK("answer seen", 1'b1, cli.ans_seen)
      `CHK("answer frame", e, cli.ans)
   endtask

   task automatic expect_abort(input logic [15:0] ix, input logic [7:0] sb,
                               input logic [31:0] code);
      expect_ans(cli.frm(rsp_id, 8'h80, ix, sb, code));
   endtask

   // Expected segments follow from the bytes already sent, not the design.
   task automatic run_seg(input int nseg);
      sdo_frame_s e;
      int rem;
      int k;
      for (int s = 0; s < nseg; s++) begin
         rem = SLEN - sent;
         k = (rem > 7) ? 7 : rem;
         e = cli.frm(rsp_id, {3'h0, cli.tog_r, 3'(7 - k), 1'(rem <= 7)},
                     16'h0, 8'h0, 32'h0);
         for (int j = 0; j < k; j++) begin
            e.data[1 + j] = chr(sent + j);
         end
         cli.seg(str_index, 8'h00);
         expect_ans(e);
         sent += k;
         if (rem <= 7) break;
      end
   endtask

   task automatic open_str;
      sent = 0;
      cli.init(str_index, 8'h00);
      expect_ans(cli.frm(rsp_id, 8'h41, str_index, 8'h00, SLEN));
   endtask

   initial begin
      rst = 1'b1;
      obj_wr_en = 1'b0;
      obj_wr_addr = 8'h00;
      obj_wr_data = 8'h00;
      node_id = 7'h05;
      word_index = 16'h2A10;
      word_value = 16'h0240;
      str_index = 16'h3B20;
      str_len = 9'(SLEN);
      repeat (3) @(negedge clock);
      rst = 1'b0;
      `CHK("open after reset", 1'b0, xfer_open)
      for (int i = 0; i < SLEN; i++) begin
         @(negedge clock);
         obj_wr_en = 1'b1;
         obj_wr_addr = 8'(i);
         obj_wr_data = chr(i);
      end
      @(negedge clock);
      obj_wr_en = 1'b0;
      cli.init(word_index, 8'h00);
      expect_ans(cli.frm(rsp_id, 8'h4B, word_index, 8'h00,
                         {16'h0, word_value}));
      for (int k = 1; k <= SLEN; k += SLEN - 1) begin
         cli.init(str_index, 8'(k));
         expect_ans(cli.frm(rsp_id, 8'h4F, str_index, 8'(k),
                            {24'h0, chr(k - 1)}));
      end
      open_str();
      run_seg(9);
      open_str();
      run_seg(1);
      open_str();
      run_seg(9);
      open_str();
      run_seg(1);
      cli.abort(str_index, 32'hDEADBEEF);
      `CHK("abort answered", 1'b0, cli.ans_seen)
      `CHK("open after abort", 1'b0, xfer_open)
      open_str();
      run_seg(9);
      open_str();
      run_seg(1);
      cli.xchg(cli.frm(11'h600 + 11'(node_id), 8'h60, str_index, 8'h00,
                       32'h0));
      expect_abort(str_index, 8'h00, 32'h05030000);
      `CHK("open after toggle error", 1'b0, xfer_open)
      cli.xchg(cli.frm(11'h600 + 11'(node_id), 8'h60, str_index, 8'h00,
                       32'h0));
      expect_abort(str_index, 8'h00, 32'h05040001);
      cli.xchg(cli.frm(11'h600 + 11'(node_id), 8'hE0, word_index, 8'h00,
                       32'h0));
      expect_abort(word_index, 8'h00, 32'h05040001);
      cli.init(16'h7777, 8'h00);
      expect_abort(16'h7777, 8'h00, 32'h06020000);
      cli.init(word_index, 8'h01);
      expect_abort(word_index, 8'h01, 32'h06090011);
      cli.xchg(cli.frm(11'h601 + 11'(node_id), 8'h40, word_index, 8'h00,
                       32'h0));
      `CHK("foreign id answered", 1'b0, cli.ans_seen)
      cli.xchg({11'h600 + 11'(node_id), 4'h7, 64'h0000000000102A40});
      `CHK("short frame answered", 1'b0, cli.ans_seen)
      close_out();
   end
endmodule // sdo_segmented_upload_server_bench
